// file: verilog/scfg_top.sv
// Switch configuration interface: EEPROM loader, I2C slave, SPI slave, register file
module scfg_top
#(
  parameter int unsigned                         SCL_HZ      = 100_000,
  parameter int unsigned                         LOAD_LIMIT  = scfg_pkg::LOAD_LIMIT_CYC,
  parameter logic [7:0]                          EEPROM_ADDR = 8'hA0,
  parameter logic [7:0]                          STRAP_REG   = 8'h00,
  parameter logic [scfg_pkg::REG_COUNT-1:0]      RO_MAP      = '0
)
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] boot_interface_strap,
  input  wire logic       power_down_n,
  input  wire logic [7:0] strap_config,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       spi_select_n,
  input  wire logic       spi_serial_clock,
  input  wire logic       spi_serial_in,
  output logic            spi_serial_out,
  output logic            spi_serial_out_oe,
  input  wire logic [7:0] cfg_rd_addr,
  output logic [7:0]      cfg_rd_data,
  output logic            switch_run,
  output logic            load_busy,
  output logic            load_ok
);
  import scfg_pkg::*;

  localparam int unsigned QTR = CLK_HZ / (4 * SCL_HZ);
  localparam int unsigned DW  = $clog2(QTR);
  localparam int unsigned TW  = $clog2(LOAD_LIMIT + 1);

  if (QTR < 2 || LOAD_LIMIT < 2 || CLK_HZ < 4 * SPI_MAX_HZ)
    $error("scfg_top: clock too slow for serial rates");

  logic [7:0]  regs_q [REG_COUNT];
  scfg_mode_t  mode_q;
  logic        mode_ok_q;
  logic        is_mst;
  logic        is_i2cs;
  logic        is_spi;

  // Straps caught after release once power-down is high; until then everything is held off
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_q    <= MODE_NONE;
      mode_ok_q <= 1'b0;
    end
    else if (!mode_ok_q && power_down_n)
    begin
      mode_q    <= scfg_mode_t'(boot_interface_strap);
      mode_ok_q <= 1'b1;
    end
  end

  assign is_mst  = mode_ok_q && mode_q == MODE_I2C_MST;
  assign is_i2cs = mode_ok_q && mode_q == MODE_I2C_SLV;
  assign is_spi  = mode_ok_q && mode_q == MODE_SPI_SLV;

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    return (a < REG_COUNT) ? regs_q[a] : 8'h00;
  endfunction

  // EEPROM loader, I2C master with quarter-bit ticks
  scfg_mst_t   mst_q;
  logic [1:0]  qtr_q;
  logic [3:0]  mbit_q;
  logic [1:0]  step_q;
  logic [7:0]  idx_q;
  logic [7:0]  msh_q;
  logic        m_scl_low_q;
  logic        m_sda_low_q;
  logic        nack_q;
  logic        ok_q;
  logic [DW-1:0] div_q;
  logic [TW-1:0] tmr_q;
  logic        tick;
  logic        stretch;
  logic        m_wr;
  logic        rx_end;
  logic        rx_end_skip;

  // Slave holding SCL low stalls the divider
  assign stretch = !m_scl_low_q && !scl_in;
  assign tick    = (div_q == DW'(QTR - 1)) && !stretch;
  assign rx_end  = (idx_q == LOAD_COUNT) || (idx_q == 8'h00 && msh_q != EE_SIGNATURE);
  assign m_wr    = tick && mst_q == M_RX && mbit_q == 4'h8 && qtr_q == 2'h0 && !rx_end_skip;

  // Byte zero is the signature and never stored
  assign rx_end_skip = (idx_q == 8'h00);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      div_q <= '0;
    else if (mst_q == M_IDLE || mst_q == M_DONE || tick)
      div_q <= '0;
    else if (!stretch)
      div_q <= div_q + DW'(1);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      tmr_q <= '0;
    else if (mst_q != M_IDLE && mst_q != M_DONE && tmr_q != TW'(LOAD_LIMIT - 1))
      tmr_q <= tmr_q + TW'(1);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mst_q       <= M_IDLE;
      qtr_q       <= 2'h0;
      mbit_q      <= 4'h0;
      step_q      <= 2'h0;
      idx_q       <= 8'h00;
      msh_q       <= 8'h00;
      m_scl_low_q <= 1'b0;
      m_sda_low_q <= 1'b0;
      nack_q      <= 1'b0;
      ok_q        <= 1'b0;
    end
    else if (mst_q == M_IDLE)
    begin
      if (is_mst)
        mst_q <= M_START;
    end
    else if (mst_q != M_DONE && mst_q != M_STOP && tmr_q == TW'(LOAD_LIMIT - 1))
    begin
      mst_q <= M_STOP;
      qtr_q <= 2'h0;
    end
    else if (tick)
    begin
      qtr_q <= qtr_q + 2'h1;
      case (mst_q)
        M_START:
        begin
          // Works as first and as repeated start
          case (qtr_q)
            2'h0: m_sda_low_q <= 1'b0;
            2'h1: m_scl_low_q <= 1'b0;
            2'h2: m_sda_low_q <= 1'b1;
            default:
            begin
              m_scl_low_q <= 1'b1;
              mst_q       <= M_TX;
              mbit_q      <= 4'h0;
              msh_q       <= (step_q == 2'h0) ? EEPROM_ADDR : (EEPROM_ADDR | 8'h01);
            end
          endcase
        end
        M_TX:
        begin
          case (qtr_q)
            2'h0:
            begin
              m_scl_low_q <= 1'b1;
              m_sda_low_q <= (mbit_q != 4'h8) && !msh_q[7];
            end
            2'h1: m_scl_low_q <= 1'b0;
            2'h2: nack_q <= (mbit_q == 4'h8) && sda_in;
            default:
            begin
              m_scl_low_q <= 1'b1;
              mbit_q      <= mbit_q + 4'h1;
              msh_q       <= {msh_q[6:0], 1'b0};
              if (mbit_q == 4'h8)
              begin
                mbit_q <= 4'h0;
                // No answer means no EEPROM: defaults stay
                if (nack_q)
                  mst_q <= M_STOP;
                else if (step_q == 2'h0)
                begin
                  step_q <= 2'h1;
                  msh_q  <= EE_WORD_START;
                end
                else if (step_q == 2'h1)
                begin
                  step_q <= 2'h2;
                  mst_q  <= M_START;
                end
                else
                begin
                  mst_q <= M_RX;
                  idx_q <= 8'h00;
                end
              end
            end
          endcase
        end
        M_RX:
        begin
          case (qtr_q)
            2'h0:
            begin
              m_scl_low_q <= 1'b1;
              m_sda_low_q <= (mbit_q == 4'h8) && !rx_end;
              if (mbit_q == 4'h8)
                nack_q <= rx_end;
            end
            2'h1: m_scl_low_q <= 1'b0;
            2'h2:
            begin
              if (mbit_q != 4'h8)
                msh_q <= {msh_q[6:0], sda_in};
            end
            default:
            begin
              m_scl_low_q <= 1'b1;
              mbit_q      <= mbit_q + 4'h1;
              if (mbit_q == 4'h8)
              begin
                mbit_q <= 4'h0;
                idx_q  <= idx_q + 8'h01;
                if (nack_q)
                begin
                  mst_q <= M_STOP;
                  ok_q  <= (idx_q == LOAD_COUNT);
                end
              end
            end
          endcase
        end
        M_STOP:
        begin
          case (qtr_q)
            2'h0:
            begin
              m_scl_low_q <= 1'b1;
              m_sda_low_q <= 1'b1;
            end
            2'h1: m_scl_low_q <= 1'b0;
            2'h2: m_sda_low_q <= 1'b0;
            default: mst_q <= M_DONE;
          endcase
        end
        default: mst_q <= mst_q;
      endcase
    end
  end

  // I2C slave, EEPROM-like register addressing
  scfg_slv_t  sst_q;
  logic [3:0] sbit_q;
  logic [7:0] ssh_q;
  logic [7:0] saddr_q;
  logic       srd_q;
  logic       s_sda_low_q;
  logic       scl_prev_q;
  logic       sda_prev_q;
  logic       s_rise;
  logic       s_fall;
  logic       s_start;
  logic       s_stop;
  logic       s_wr;

  assign s_rise  = scl_in && !scl_prev_q;
  assign s_fall  = !scl_in && scl_prev_q;
  assign s_start = scl_in && scl_prev_q && sda_prev_q && !sda_in;
  assign s_stop  = scl_in && scl_prev_q && !sda_prev_q && sda_in;
  assign s_wr    = is_i2cs && s_fall && !s_start && !s_stop && sbit_q == 4'h8 && sst_q == S_WR;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sst_q       <= S_IDLE;
      sbit_q      <= 4'h0;
      ssh_q       <= 8'h00;
      saddr_q     <= 8'h00;
      srd_q       <= 1'b0;
      s_sda_low_q <= 1'b0;
    end
    else if (!is_i2cs || s_stop)
    begin
      sst_q       <= S_IDLE;
      s_sda_low_q <= 1'b0;
    end
    else if (s_start)
    begin
      sst_q       <= S_ADDR;
      sbit_q      <= 4'h0;
      s_sda_low_q <= 1'b0;
    end
    else if (s_rise && sst_q != S_IDLE)
    begin
      if (sbit_q == 4'h8)
      begin
        sbit_q <= 4'h0;
        case (sst_q)
          S_ADDR:
          begin
            sst_q <= srd_q ? S_RD : S_REG;
            if (srd_q)
              ssh_q <= rd_reg(saddr_q);
          end
          S_REG: sst_q <= S_WR;
          S_RD:
          begin
            // Master NACK ends the read
            if (sda_in)
              sst_q <= S_IDLE;
            else
            begin
              saddr_q <= scfg_next_addr(saddr_q);
              ssh_q   <= rd_reg(scfg_next_addr(saddr_q));
            end
          end
          default: sst_q <= sst_q;
        endcase
      end
      else
      begin
        sbit_q <= sbit_q + 4'h1;
        if (sst_q != S_RD)
          ssh_q <= {ssh_q[6:0], sda_in};
      end
    end
    else if (s_fall && sst_q != S_IDLE)
    begin
      if (sbit_q == 4'h8)
      begin
        s_sda_low_q <= (sst_q != S_RD);
        case (sst_q)
          S_ADDR:
          begin
            srd_q <= (ssh_q == I2C_DEV_RD);
            if (ssh_q != I2C_DEV_RD && ssh_q != I2C_DEV_WR)
            begin
              sst_q       <= S_IDLE;
              s_sda_low_q <= 1'b0;
            end
          end
          S_REG: saddr_q <= ssh_q;
          S_WR: saddr_q <= scfg_next_addr(saddr_q);
          default: sst_q <= sst_q;
        endcase
      end
      else
        s_sda_low_q <= (sst_q == S_RD) && !ssh_q[3'(4'h7 - sbit_q)];
    end
  end

  // SPI slave
  scfg_wr_t   spi_wr;
  logic [7:0] spi_addr;
  logic [7:0] spi_rd;

  // Function reads the array, so a process keeps it fresh
  always_comb
  begin
    spi_rd = rd_reg(spi_addr);
  end

  scfg_spi_slave scfg_spi_slave_inst
  (
    .sys_clk           (sys_clk),
    .rstn              (rstn),
    .enable            (is_spi),
    .spi_select_n      (spi_select_n),
    .spi_serial_clock  (spi_serial_clock),
    .spi_serial_in     (spi_serial_in),
    .rd_data           (spi_rd),
    .rd_addr           (spi_addr),
    .wr                (spi_wr),
    .spi_serial_out    (spi_serial_out),
    .spi_serial_out_oe (spi_serial_out_oe)
  );

  // Register file, one write port; modes never overlap
  logic       w_en;
  logic [7:0] w_addr;
  logic [7:0] w_data;

  always_comb
  begin
    w_en   = 1'b0;
    w_addr = 8'h00;
    w_data = 8'h00;
    if (m_wr)
    begin
      w_en   = 1'b1;
      w_addr = 8'(idx_q - 8'h01);
      w_data = msh_q;
    end
    else if (s_wr)
    begin
      w_en   = 1'b1;
      w_addr = saddr_q;
      w_data = ssh_q;
    end
    else if (spi_wr.en)
    begin
      w_en   = 1'b1;
      w_addr = spi_wr.addr;
      w_data = spi_wr.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs_q[i] <= 8'h00;
    end
    else
    begin
      if (!mode_ok_q && power_down_n)
        regs_q[STRAP_REG] <= strap_config;
      // Writes allowed at any time, also after start
      if (w_en && w_addr < REG_COUNT && !RO_MAP[w_addr])
      begin
        if (w_addr == RUN_REG)
        begin
          regs_q[RUN_REG]          <= w_data;
          regs_q[RUN_REG][RUN_BIT] <= w_data[RUN_BIT] | regs_q[RUN_REG][RUN_BIT];
        end
        else
          regs_q[w_addr] <= w_data;
      end
    end
  end

  // Status and host read-out
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_rd_data <= 8'h00;
      switch_run  <= 1'b0;
      load_busy   <= 1'b0;
      load_ok     <= 1'b0;
    end
    else
    begin
      cfg_rd_data <= rd_reg(cfg_rd_addr);
      load_busy   <= is_mst && mst_q != M_DONE;
      load_ok     <= ok_q && mst_q == M_DONE;
      if (is_mst)
        switch_run <= (mst_q == M_DONE);
      else if (is_i2cs || is_spi)
        switch_run <= regs_q[RUN_REG][RUN_BIT];
      else
        switch_run <= mode_ok_q;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = m_scl_low_q;
  assign sda_oe  = m_sda_low_q || s_sda_low_q;

endmodule

// file: verilog/scfg_pkg.sv
// Shared constants, types and helpers of the switch configuration interface
package scfg_pkg;

  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned REG_COUNT       = 142;
  localparam logic [7:0]  REG_LAST        = 8'h8D;
  localparam logic [7:0]  LOAD_COUNT      = 8'h79;
  localparam logic [7:0]  EE_SIGNATURE    = 8'h88;
  localparam logic [7:0]  EE_WORD_START   = 8'h00;
  localparam logic [7:0]  I2C_DEV_RD      = 8'hBF;
  localparam logic [7:0]  I2C_DEV_WR      = 8'hBE;
  localparam logic [7:0]  SPI_CMD_RD      = 8'h03;
  localparam logic [7:0]  SPI_CMD_WR      = 8'h02;
  localparam logic [7:0]  RUN_REG         = 8'h01;
  localparam int unsigned RUN_BIT         = 0;
  localparam int unsigned SPI_MAX_HZ      = 5_000_000;
  localparam int unsigned LOAD_TIME_MS    = 15;
  localparam int unsigned LOAD_LIMIT_CYC  = (CLK_HZ / 1000) * LOAD_TIME_MS;

  typedef enum logic [1:0]
  {
    MODE_I2C_MST = 2'h0,
    MODE_I2C_SLV = 2'h1,
    MODE_SPI_SLV = 2'h2,
    MODE_NONE    = 2'h3
  } scfg_mode_t;

  typedef enum logic [5:0]
  {
    M_IDLE  = 6'h01,
    M_START = 6'h02,
    M_TX    = 6'h04,
    M_RX    = 6'h08,
    M_STOP  = 6'h10,
    M_DONE  = 6'h20
  } scfg_mst_t;

  typedef enum logic [4:0]
  {
    S_IDLE = 5'h01,
    S_ADDR = 5'h02,
    S_REG  = 5'h04,
    S_WR   = 5'h08,
    S_RD   = 5'h10
  } scfg_slv_t;

  typedef struct packed
  {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } scfg_wr_t;

  function automatic logic [7:0] scfg_next_addr(input logic [7:0] a);
    return (a >= REG_LAST) ? 8'h00 : 8'(a + 8'h01);
  endfunction

endpackage

// file: verilog/scfg_spi_slave.sv
// SPI slave: command, register address and auto-incrementing data bytes
module scfg_spi_slave
(
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             enable,
  input  wire logic             spi_select_n,
  input  wire logic             spi_serial_clock,
  input  wire logic             spi_serial_in,
  input  wire logic [7:0]       rd_data,
  output logic [7:0]            rd_addr,
  output scfg_pkg::scfg_wr_t    wr,
  output logic                  spi_serial_out,
  output logic                  spi_serial_out_oe
);
  import scfg_pkg::*;

  logic       sck_q;
  logic [2:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] ish_q;
  logic [7:0] osh_q;
  logic [7:0] addr_q;
  logic       is_rd_q;
  logic       is_wr_q;
  logic       so_q;
  scfg_wr_t   wr_q;
  logic       rise;
  logic       fall;
  logic [7:0] byte_in;

  assign rise    = spi_serial_clock && !sck_q;
  assign fall    = !spi_serial_clock && sck_q;
  assign byte_in = {ish_q[6:0], spi_serial_in};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sck_q <= 1'b0;
    else
      sck_q <= spi_serial_clock;
  end

  // Input sampled on rising serial clock, byte framing
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_q   <= 3'h0;
      byte_q  <= 2'h0;
      ish_q   <= 8'h00;
      addr_q  <= 8'h00;
      is_rd_q <= 1'b0;
      is_wr_q <= 1'b0;
      wr_q    <= '0;
    end
    else if (!enable || spi_select_n)
    begin
      bit_q   <= 3'h0;
      byte_q  <= 2'h0;
      is_rd_q <= 1'b0;
      is_wr_q <= 1'b0;
      wr_q.en <= 1'b0;
    end
    else
    begin
      wr_q.en <= 1'b0;
      if (rise)
      begin
        ish_q <= byte_in;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7)
        begin
          case (byte_q)
            2'h0:
            begin
              is_rd_q <= (byte_in == SPI_CMD_RD);
              is_wr_q <= (byte_in == SPI_CMD_WR);
              byte_q  <= 2'h1;
            end
            2'h1:
            begin
              addr_q <= byte_in;
              byte_q <= 2'h2;
            end
            default:
            begin
              if (is_wr_q)
                wr_q <= '{en: 1'b1, addr: addr_q, data: byte_in};
              // Wraps past the last register
              if (is_rd_q || is_wr_q)
                addr_q <= scfg_next_addr(addr_q);
            end
          endcase
        end
      end
    end
  end

  // Read data launched on falling serial clock
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      so_q  <= 1'b0;
      osh_q <= 8'h00;
    end
    else if (enable && !spi_select_n && fall && is_rd_q && byte_q == 2'h2)
    begin
      if (bit_q == 3'h0)
      begin
        so_q  <= rd_data[7];
        osh_q <= {rd_data[6:0], 1'b0};
      end
      else
      begin
        so_q  <= osh_q[7];
        osh_q <= {osh_q[6:0], 1'b0};
      end
    end
  end

  assign rd_addr           = addr_q;
  assign wr                = wr_q;
  assign spi_serial_out    = so_q;
  assign spi_serial_out_oe = enable && !spi_select_n;

endmodule

// file: verif/scfg_checker.sv
// Port-level checker of the configuration block
module scfg_checker
#(
  parameter int unsigned LOAD_LIMIT = 20000
)
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       spi_select_n,
  input wire logic       spi_serial_clock,
  input wire logic       spi_serial_out,
  input wire logic       spi_serial_out_oe,
  input wire logic [7:0] cfg_rd_addr,
  input wire logic [7:0] cfg_rd_data,
  input wire logic       switch_run,
  input wire logic       load_busy,
  input wire logic       load_ok,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy_cnt_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // Margin covers the closing stop after a cut-off load
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      busy_cnt_q <= 32'h0;
    else if (load_busy)
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end
  property p_first_run;
    !$past(rstn) |-> !switch_run;
  endproperty
  a_first_run: assert property (p_first_run) else $error("run high right after reset");
  property p_run_sticky;
    switch_run |=> switch_run;
  endproperty
  a_run_sticky: assert property (p_run_sticky) else $error("run dropped");
  property p_oe_sel;
    spi_serial_out_oe |-> !spi_select_n;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("serial out driven while deselected");
  property p_launch;
    spi_serial_out_oe && $past(spi_serial_out_oe) && $changed(spi_serial_out) |-> !spi_serial_clock;
  endproperty
  a_launch: assert property (p_launch) else $error("serial out moved with clock high");
  property p_cfg_range;
    cfg_rd_addr >= 8'h8E |=> cfg_rd_data == 8'h00;
  endproperty
  a_cfg_range: assert property (p_cfg_range) else $error("data beyond last register");
  property p_busy_ok;
    load_busy |-> !load_ok;
  endproperty
  a_busy_ok: assert property (p_busy_ok) else $error("load good while busy");
  property p_busy_halt;
    load_busy |-> !switch_run;
  endproperty
  a_busy_halt: assert property (p_busy_halt) else $error("switching during load");
  property p_open_drain;
    !scl_out && !sda_out && (load_busy || !scl_oe);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("bus line driven high or clock held");
  property p_load_bound;
    busy_cnt_q <= LOAD_LIMIT + 32'd1000;
  endproperty
  a_load_bound: assert property (p_load_bound) else $error("load too long");
  c_run: cover property ($rose(switch_run));
  c_read: cover property (spi_serial_out_oe [*8]);
  c_load: cover property ($fell(load_busy));
endmodule

bind scfg_top scfg_checker #(.LOAD_LIMIT(LOAD_LIMIT)) scfg_checker_inst
(
  .sys_clk           (sys_clk),
  .rstn              (rstn),
  .spi_select_n      (spi_select_n),
  .spi_serial_clock  (spi_serial_clock),
  .spi_serial_out    (spi_serial_out),
  .spi_serial_out_oe (spi_serial_out_oe),
  .cfg_rd_addr       (cfg_rd_addr),
  .cfg_rd_data       (cfg_rd_data),
  .switch_run        (switch_run),
  .load_busy         (load_busy),
  .load_ok           (load_ok),
  .scl_out           (scl_out),
  .scl_oe            (scl_oe),
  .sda_out           (sda_out)
);

// file: verif/scfg_spi_host.sv
// Partner models of the configuration port: SPI host and serial EEPROM
module scfg_spi_host
#(
  parameter int HALF = 5
)
(
  input  wire logic sys_clk,
  input  wire logic miso,
  output logic      sel_n,
  output logic      sclk,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    mosi  = 1'b0;
  end
  // Five system clocks a phase keeps the rate at 2.5 MHz
  task automatic wt();
    repeat (HALF) @(negedge sys_clk);
  endtask
  task automatic start();
    sel_n = 1'b0;
    wt();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = tx[i];
      wt();
      sclk = 1'b1;
      rx[i] = miso;
      wt();
    end
  endtask
  task automatic stop();
    sclk = 1'b0;
    wt();
    sel_n = 1'b1;
    mosi  = ~mosi;
    wt();
  endtask
endmodule

// Serial EEPROM on the open-drain pair, sequential read only
module scfg_eeprom
(
  input  wire logic       sys_clk,
  input  wire logic       present,
  input  wire logic [7:0] sig,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       first = 1'b0;
  logic       rdgo  = 1'b0;
  logic       dat   = 1'b0;
  logic [3:0] n     = 4'h0;
  logic [7:0] sh    = 8'h00;
  logic [7:0] ptr   = 8'h00;
  logic [7:0] img;
  initial sda_low = 1'b0;
  // Byte zero is the signature, byte k holds k xor A5
  assign img = (ptr == 8'h00) ? sig : (ptr ^ 8'hA5);
  always @(posedge sys_clk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda)
    begin
      n     <= 4'h0;
      first <= 1'b1;
      rdgo  <= 1'b0;
      dat   <= 1'b0;
    end
    else if (scl && !scl_q)
    begin
      if (n != 4'h8)
      begin
        sh <= {sh[6:0], sda};
        n  <= n + 4'h1;
      end
      else
      begin
        n    <= 4'h0;
        rdgo <= 1'b0;
        dat  <= rdgo || (dat && !sda);
        if (dat && !sda)
          ptr <= ptr + 8'h01;
      end
    end
    else if (!scl && scl_q)
    begin
      if (n != 4'h8)
        sda_low <= dat && !img[3'(4'h7 - n)];
      else if (dat)
        sda_low <= 1'b0;
      else
      begin
        sda_low <= present;
        first   <= 1'b0;
        rdgo    <= present && first && sh[0];
        if (!first)
          ptr <= sh;
      end
    end
  end
endmodule

// file: verif/scfg_tb_top.sv
// Testbench of the configuration block in SPI and loader modes
module scfg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rstn;
  logic [1:0]  strap;
  logic        sel_n;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        scl_oe;
  logic        sda_oe;
  logic [7:0]  cfg_rd_addr = 8'h00;
  logic [7:0]  cfg_rd_data;
  logic        switch_run;
  logic        load_busy;
  logic        load_ok;
  logic        ee_on = 1'b0;
  logic [7:0]  ee_sig = 8'h88;
  logic        ee_low;
  logic        pd_n = 1'b1;
  wire         scl_ln = ~scl_oe;
  wire         sda_ln = ~(sda_oe | ee_low);
  logic [7:0]  rd [3];
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #20 sys_clk = ~sys_clk;
  scfg_top #(.SCL_HZ(2_000_000), .LOAD_LIMIT(20000)) scfg_top_inst
  (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .boot_interface_strap (strap),
    .power_down_n         (pd_n),
    .strap_config         (8'h5A),
    .scl_in               (scl_ln),
    .scl_out              (),
    .scl_oe               (scl_oe),
    .sda_in               (sda_ln),
    .sda_out              (),
    .sda_oe               (sda_oe),
    .spi_select_n         (sel_n),
    .spi_serial_clock     (sclk),
    .spi_serial_in        (mosi),
    .spi_serial_out       (miso),
    .spi_serial_out_oe    (),
    .cfg_rd_addr          (cfg_rd_addr),
    .cfg_rd_data          (cfg_rd_data),
    .switch_run           (switch_run),
    .load_busy            (load_busy),
    .load_ok              (load_ok)
  );
  scfg_spi_host scfg_spi_host_inst
  (
    .sys_clk (sys_clk),
    .miso    (miso),
    .sel_n   (sel_n),
    .sclk    (sclk),
    .mosi    (mosi)
  );
  scfg_eeprom scfg_eeprom_inst
  (
    .sys_clk (sys_clk),
    .present (ee_on),
    .sig     (ee_sig),
    .scl     (scl_ln),
    .sda     (sda_ln),
    .sda_low (ee_low)
  );
  task automatic print_verdict();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    cfg_rd_addr = a;
    repeat (2) @(negedge sys_clk);
    chk(cfg_rd_data, exp);
  endtask
  // Released lines read high through the pull-ups
  task automatic boot(input logic [1:0] s);
    rstn  = 1'b0;
    strap = s;
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] a, input int n, input logic [7:0] wd [3]);
    logic [7:0] x;
    scfg_spi_host_inst.start();
    scfg_spi_host_inst.xfer(cmd, x);
    scfg_spi_host_inst.xfer(a, x);
    for (int i = 0; i < n; i++)
      scfg_spi_host_inst.xfer(wd[i], rd[i]);
    scfg_spi_host_inst.stop();
  endtask
  task automatic load(input logic on, input logic [7:0] sig);
    ee_on  = on;
    ee_sig = sig;
    boot(2'h0);
    chk(load_busy, 8'h01);
    for (int i = 0; i < 30000 && load_busy; i++)
      @(negedge sys_clk);
    chk(load_busy, 8'h00);
    chk(switch_run, 8'h01);
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      print_verdict();
    end
  end
  initial
  begin
    boot(2'h2);
    chk(switch_run, 8'h00);
    peek(8'h00, 8'h5A);
    peek(8'h8E, 8'h00);
    $display("test reset done");
    frame(8'h02, 8'h8C, 3, '{8'h11, 8'h22, 8'h33});
    peek(8'h8C, 8'h11);
    peek(8'h8D, 8'h22);
    peek(8'h00, 8'h33);
    frame(8'h03, 8'h8D, 2, '{8'h00, 8'h00, 8'h00});
    chk(rd[0], 8'h22);
    chk(rd[1], 8'h33);
    frame(8'h05, 8'h8C, 1, '{8'h77, 8'h00, 8'h00});
    peek(8'h8C, 8'h11);
    $display("test burst done");
    frame(8'h02, 8'h01, 1, '{8'h01, 8'h00, 8'h00});
    chk(switch_run, 8'h01);
    frame(8'h02, 8'h01, 2, '{8'h00, 8'h44, 8'h00});
    chk(switch_run, 8'h01);
    peek(8'h01, 8'h01);
    peek(8'h02, 8'h44);
    $display("test run done");
    boot(2'h1);
    chk(switch_run, 8'h00);
    frame(8'h02, 8'h02, 1, '{8'h66, 8'h00, 8'h00});
    peek(8'h02, 8'h00);
    boot(2'h3);
    chk(switch_run, 8'h01);
    $display("test mode done");
    pd_n = 1'b0;
    boot(2'h0);
    chk(load_busy, 8'h00);
    chk(switch_run, 8'h00);
    pd_n = 1'b1;
    load(1'b0, 8'h88);
    chk(load_ok, 8'h00);
    peek(8'h00, 8'h5A);
    load(1'b1, 8'h87);
    chk(load_ok, 8'h00);
    peek(8'h00, 8'h5A);
    load(1'b1, 8'h88);
    chk(load_ok, 8'h01);
    peek(8'h00, 8'hA4);
    peek(8'h01, 8'hA7);
    peek(8'h78, 8'hDC);
    peek(8'h79, 8'h00);
    $display("test load done");
    print_verdict();
  end
endmodule
